// ==== hw/scr_top.sv ====
// Conversion sequencer and serial result shifter
`timescale 1ns/1ps
module scr_top
  import scr_pkg::*;
#(
  parameter int CONV_CYC = scr_pkg::CONV_MAX_CYC,
  parameter int ACQ_CYC = scr_pkg::ACQ_START_CYC,
  parameter int POR_CYC = scr_pkg::POR_WAIT_CYC
)
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Conversion control pins
  input wire logic conversion_trigger,
  output logic busy,
  output logic acquiring,
  output logic powered_down,
  output logic por_ready,
  // Analog core result
  input wire logic [scr_pkg::RESULT_W-1:0] core_result,
  // Serial port pins
  input wire logic sck,
  input wire logic read_select_or_chain_input,
  input wire logic chain_select,
  output logic sdo_o,
  output logic sdo_oe
);
  import scr_pkg::*;

  // Overview of the cycle flow
  // Pins cross into the clock domain through two flops each.
  // Edges are found one cycle later against a delayed copy.
  // A trigger rise is therefore acted on three clocks after the pin.
  // Busy rises on the clock after the edge is seen.
  // Busy then stands for exactly CONV_CYC clocks, never shorter.
  // Fixed length keeps the worst case inside the conversion budget.
  // Trade-off: no early finish, so throughput is set by the limit.
  // The last busy cycle loads the result and presents its top bit.
  // Busy falls on the same edge that makes the top bit visible.
  // Serial clock rises are ignored while busy is high.
  // A serial clock rise with the output released shifts nothing.
  // Each accepted rise moves the next lower bit onto the output.
  // Chain input fills the word from below in chain mode.
  // In normal mode zeros fill from below instead.
  // After twenty rises the word is spent and only fill bits remain.
  // Serial clock phases must each last at least two clocks.
  // Shorter phases can be missed by the edge detector.
  // Limitation: serial clock limited to a quarter of the system clock.
  // Acquiring goes high ACQ_CYC clocks into a conversion.
  // Acquiring stays high through the whole power-down period.
  // The power-on timer only reports readiness, it gates nothing.
  // Early triggers still start conversions, with untrusted results.

  // Refuse timing values the counters cannot serve
  if (CONV_CYC < 2 || CONV_CYC > CONV_MAX_CYC || ACQ_CYC < 1 ||
      ACQ_CYC >= CONV_CYC || POR_CYC < 1 || POR_CYC > 65535)
  begin : g_bad_timing
    $error("scr_top: bad timing parameters");
  end

  scr_sync_if s ();
  scr_sync u_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .pins({read_select_or_chain_input, chain_select,
           read_select_or_chain_input, sck, conversion_trigger}),
    .q(s)
  );

  scr_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] por_ff;
  logic trig_d_ff, sck_d_ff;
  logic [RESULT_W-1:0] shift_ff, nxt_shift;
  logic sdo_ff, nxt_sdo;

  // Edge detection on synchronised levels
  wire trig_rise = s.trig & ~trig_d_ff;
  wire sck_rise = s.sck & ~sck_d_ff;
  wire conv_done = (state_ff == SCR_CONV) &&
                   (cnt_ff == CNT_W'(CONV_CYC - 1));
  // Chain mode keeps SDO on; normal mode follows read select
  wire sdo_en = s.chain | ~s.rsel;
  wire por_done = (por_ff == CNT_W'(POR_CYC));

  // Sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      SCR_OFF:
      begin
        if (trig_rise)
        begin
          nxt_state = SCR_CONV;
          nxt_cnt = '0;
        end
      end
      SCR_CONV:
      begin
        // Triggers not looked at here, so no restart
        if (conv_done)
          nxt_state = SCR_DOWN;
        else
          nxt_cnt = cnt_ff + CNT_W'(1);
      end
      SCR_DOWN:
      begin
        if (trig_rise)
        begin
          nxt_state = SCR_CONV;
          nxt_cnt = '0;
        end
      end
      default:
      begin
        nxt_state = SCR_OFF;
        nxt_cnt = '0;
      end
    endcase
  end

  // Shift register: load at conversion end, shift on SCK rise
  always_comb
  begin
    nxt_shift = shift_ff;
    nxt_sdo = sdo_ff;
    if (conv_done)
    begin
      nxt_shift = core_result;
      nxt_sdo = core_result[RESULT_W-1];
    end
    else if (sck_rise && sdo_en && state_ff != SCR_CONV)
    begin
      // Chain input fills from below, so data follows after 20 bits
      nxt_shift = {shift_ff[RESULT_W-2:0], s.chain & s.chain_in};
      nxt_sdo = shift_ff[RESULT_W-2];
    end
  end

  // State and counters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= SCR_OFF;
      cnt_ff <= '0;
      trig_d_ff <= 1'b0;
      sck_d_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      trig_d_ff <= s.trig;
      sck_d_ff <= s.sck;
    end
  end

  // Result storage and output bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_ff <= RESULT_RST;
      sdo_ff <= 1'b0;
    end
    else
    begin
      shift_ff <= nxt_shift;
      sdo_ff <= nxt_sdo;
    end
  end

  // Reinitialisation timer after power-on reset; ready is advisory only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      por_ff <= '0;
    else if (!por_done)
      por_ff <= por_ff + CNT_W'(1);
  end

  // Status outputs
  assign busy = (state_ff == SCR_CONV);
  assign acquiring = (state_ff != SCR_CONV) ||
                     (cnt_ff >= CNT_W'(ACQ_CYC));
  assign powered_down = (state_ff != SCR_CONV);
  assign por_ready = por_done;
  assign sdo_o = sdo_ff;
  assign sdo_oe = sdo_en;
endmodule

// ==== include/scr_pkg.sv ====
// Package: constants for the conversion control and serial readout block
package scr_pkg;
  localparam int RESULT_W = 20;
  localparam int CLK_PERIOD_PS = 4000;
  // Times in their own units
  localparam int ACQ_START_NS = 675;
  localparam int CONV_MAX_NS = 3000;
  localparam int POR_WAIT_US = 200;
  // Cycle counts at the 250 MHz clock
  localparam int ACQ_START_CYC = (ACQ_START_NS * 1000) / CLK_PERIOD_PS;
  localparam int CONV_MAX_CYC = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int POR_WAIT_CYC = (POR_WAIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;
  localparam logic [RESULT_W-1:0] RESULT_RST = 20'h0_0000;
  typedef enum logic [2:0]
  {
    SCR_OFF = 3'b001,
    SCR_CONV = 3'b010,
    SCR_DOWN = 3'b100
  } scr_state_t;
endpackage

// ==== include/scr_sync_if.sv ====
// Interface: synchronised pin levels passed from the synchroniser
`timescale 1ns/1ps
interface scr_sync_if;
  logic trig;
  logic sck;
  logic rsel;
  logic chain;
  logic chain_in;
  modport src (output trig, sck, rsel, chain, chain_in);
  modport dst (input trig, sck, rsel, chain, chain_in);
endinterface

// ==== hw/scr_sync.sv ====
// Two-flop synchronisers for every pin input
`timescale 1ns/1ps
module scr_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw pins
  input wire logic [4:0] pins,
  // Synchronised levels
  scr_sync_if.src q
);
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  // First stage read only by second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 5'h00;
      sync_ff <= 5'h00;
    end
    else
    begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
    end
  end
  assign q.trig = sync_ff[0];
  assign q.sck = sync_ff[1];
  assign q.rsel = sync_ff[2];
  assign q.chain = sync_ff[3];
  assign q.chain_in = sync_ff[4];
endmodule

// ==== sim/scr_monitor.sv ====
// Checker for the conversion sequencer and serial shifter
`timescale 1ns/1ps
module scr_monitor
  import scr_pkg::*;
#(
  parameter int CONV_CYC = 750,
  parameter int ACQ_CYC = 168
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Conversion pins
  input wire logic conversion_trigger,
  input wire logic busy,
  input wire logic acquiring,
  input wire logic powered_down,
  input wire logic [scr_pkg::RESULT_W-1:0] core_result,
  // Serial pins
  input wire logic sck,
  input wire logic read_select_or_chain_input,
  input wire logic chain_select,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic [15:0] cnt_ff;
  logic [2:0] age_ff;
  // Busy length, and age of the last serial clock rise (saturates)
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 16'h0000;
      age_ff <= 3'h7;
    end
    else
    begin
      cnt_ff <= busy ? cnt_ff + 16'h0001 : 16'h0000;
      age_ff <= $rose(sck) ? 3'h0 : age_ff + {2'h0, age_ff != 3'h7};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    $rose(conversion_trigger) && !busy;
  endsequence
  sequence s_end;
    $fell(busy);
  endsequence
  AST_START: assert property (s_start |-> ##[1:5] busy)
    else $error("no busy after trigger");
  AST_LEN: assert property (s_end |-> cnt_ff == CONV_CYC)
    else $error("conversion length wrong");
  AST_PD: assert property (powered_down != busy)
    else $error("power-down not outside conversion");
  AST_WAKE: assert property ($fell(powered_down) |->
    $past(conversion_trigger, 3) && !$past(conversion_trigger, 4))
    else $error("woke without trigger");
  AST_ACQ: assert property (busy |-> acquiring == (cnt_ff >= ACQ_CYC))
    else $error("acquisition start wrong");
  AST_MSB: assert property (s_end |-> sdo_o == core_result[RESULT_W-1])
    else $error("top bit missing at busy fall");
  AST_HOLD: assert property ($changed(sdo_o) |-> $fell(busy) ||
    (age_ff < 3'h6 && sdo_oe)) else $error("output moved without clock");
  AST_BUSY: assert property (busy && $past(busy) |-> $stable(sdo_o))
    else $error("output moved in conversion");
  AST_OFF: assert property ((!chain_select &&
    read_select_or_chain_input)[*4] |-> !sdo_oe) else $error("not released");
  AST_ON: assert property ((chain_select ||
    !read_select_or_chain_input)[*4] |-> sdo_oe) else $error("not driven");
endmodule
bind scr_top scr_monitor #(.CONV_CYC(CONV_CYC), .ACQ_CYC(ACQ_CYC))
  i_scr_monitor (.clk, .rst_n, .conversion_trigger, .busy, .acquiring,
  .powered_down, .core_result, .sck, .read_select_or_chain_input,
  .chain_select, .sdo_o, .sdo_oe);

// ==== sim/scr_host.sv ====
// Host model: conversion trigger, serial clock and result capture
`timescale 1ns/1ps
module scr_host
(
  // Clock
  input wire logic clk,
  // Host pins
  output logic trig,
  output logic sck,
  input wire logic sdo
);
  // Both lines start low; trigger is then held at its last level, serial clock stands low outside frames
  initial
  begin
    trig = 1'h0;
    sck = 1'h0;
  end
  // One clean rise, level then held: no extra edges
  task automatic convert();
    @(negedge clk) trig = 1'h0;
    @(negedge clk) trig = 1'h1;
  endtask
  // 32 ns clock; each bit taken just before the next rise
  task automatic read(output logic [scr_pkg::RESULT_W-1:0] w);
    for (int i = scr_pkg::RESULT_W - 1; i >= 0; i--)
    begin
      @(negedge clk) w[i] = sdo;
      sck = 1'h1;
      repeat (4) @(negedge clk);
      sck = 1'h0;
      repeat (3) @(negedge clk);
    end
  endtask
endmodule

// ==== sim/sar_conversion_serial_readout_tb.sv ====
// Bench: conversions and readout through the host model
`timescale 1ns/1ps
module sar_conversion_serial_readout_tb;
  import scr_pkg::*;
  logic clk = 0, rst_n = 0, rsel = 0, chain = 0;
  logic [RESULT_W-1:0] res = 20'hA_5C3E, got;
  logic trig, sck, busy, acq, pd, rdy, sdo_o, sdo_oe;
  int n_errors = 0, checks = 0;
  always #2 clk = ~clk;
  // Released line shows the inverse of the last bit
  wire sdo_pin = sdo_oe ? sdo_o : ~sdo_o;
  scr_top #(.CONV_CYC(40), .ACQ_CYC(10), .POR_CYC(20)) i_scr_top (.clk,
    .rst_n, .conversion_trigger(trig), .busy, .acquiring(acq),
    .powered_down(pd), .por_ready(rdy), .core_result(res), .sck,
    .read_select_or_chain_input(rsel), .chain_select(chain), .sdo_o,
    .sdo_oe);
  scr_host i_scr_host (.clk, .trig, .sck, .sdo(sdo_pin));
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait for a busy level
  task automatic wait_busy(input logic v);
    for (int k = 0; k < 200 && busy !== v; k++) @(negedge clk);
    check("busy", busy, v);
  endtask
  task automatic t_reset();
    repeat (6) @(negedge clk);
    check("busy", busy, 1'h0);
    check("sdo", sdo_o, 1'h0);
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    repeat (5) @(negedge clk);
    check("rdy", rdy, 1'h0);
    repeat (30) @(negedge clk);
    check("rdy", rdy, 1'h1);
  endtask
  // Stray trigger mid-conversion must not stretch it
  task automatic t_conv();
    time t0;
    i_scr_host.convert();
    wait_busy(1'h1);
    t0 = $time;
    check("pd", pd, 1'h0);
    check("acq", acq, 1'h0);
    i_scr_host.convert();
    wait_busy(1'h0);
    check("acq", acq, 1'h1);
    check("len", 32'(($time - t0) / 4), 40);
    check("pd", pd, 1'h1);
    i_scr_host.read(got);
    check("word", got, res);
  endtask
  // Clocks while released shift nothing
  task automatic t_oe();
    res = 20'hC_3A17;
    rsel = 1'h1;
    i_scr_host.convert();
    wait_busy(1'h1);
    wait_busy(1'h0);
    repeat (4) @(negedge clk);
    check("oe", sdo_oe, 1'h0);
    i_scr_host.read(got);
    check("held", sdo_o, res[19]);
    rsel = 1'h0;
    repeat (4) @(negedge clk);
    check("oe", sdo_oe, 1'h1);
    i_scr_host.read(got);
    check("word", got, res);
    chain = 1'h1;
    rsel = 1'h1;
    repeat (4) @(negedge clk);
    check("oe", sdo_oe, 1'h1);
  endtask
  initial
  begin
    t_reset();
    t_conv();
    t_oe();
    print_verdict();
  end
  // Watchdog well past the few microseconds expected
  initial
  begin
    #20000;
    n_errors++;
    print_verdict();
  end
endmodule
